/* rtl/can_phy_fault_manager.sv */
`timescale 1ns/1ns
`include "can_phy_fault_defines.svh"
// Function
// - Battery under 4.0 V sets battery fail flag, maskable interrupt.
// - Battery over 20 V sets battery high flag, interrupt, no action.
// - Failure detector works in full and receive-only modes.
// - Failure 3 or 8 opens high ground switch, disables CANH driver.
// - Failure 4, 6 or 7 opens low V2 switch, disables CANL driver; low battery switch follows standby only.
// - Failures 1, 2, 5 change no switch or driver.
// - Failures 3, 6 go single-wire after detect filter; recover after filter.
// - Failures 4, 7 after timeout drop CANL, keep weak pull-up, use CANH.
// - After 4 or 7 clear, differential after recessive recovery filter.
// - Eight wiring failures each set own flag and raise interrupt.
// - Wiring flag clears only once recovered and read.
// - Transmit dominant over 2.0 ms disables bus drivers.
// - Receive-only disables transmitter; RX dominant on TX or bus.
// - Over-temperature disables only transmitter stages.
// - Without failures RX follows the differential bus.
// - Microcontroller selects the mode; device applies it.
// - Standby disables drivers, receivers; keeps 3,4,7,8 detection.
// - Peripheral supply undervoltage forces bus standby.
// - Active-low interrupt stays asserted until source cleared.
module can_phy_fault_manager #(
	parameter int FAIL3_DETECT = `FAIL3_DETECT_CYC,
	parameter int FAIL6_DETECT = `FAIL6_DETECT_CYC,
	parameter int FAIL36_RECOVER = `FAIL36_RECOVER_CYC,
	parameter int FAIL47_TIMEOUT = `FAIL47_TIMEOUT_CYC,
	parameter int FAIL478_RECOVER = `FAIL478_RECOVER_CYC,
	parameter int TX_DOM_LIMIT = `TX_DOM_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_tx_dom,
	output logic o_rx_dom,
	input wire logic [10:0] i_sense,
	input wire logic i_batt_low,
	input wire logic i_batt_high,
	input wire logic i_v2_undervolt,
	input wire logic i_over_temp,
	output can_phy_fault_pkg::phy_ctrl_type o_phy,
	output logic o_int_n
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [14:0] sync1_ff;
	logic [14:0] sync2_ff;
	can_phy_fault_pkg::phy_sense_type sense;
	logic tx_dom;
	logic batt_low;
	logic batt_high;
	logic v2_uv;
	logic otemp;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sync1_ff <= 15'h0000;
			sync2_ff <= 15'h0000;
		end else begin
			sync1_ff <= {i_tx_dom, i_batt_low, i_batt_high, i_v2_undervolt,
				i_sense};
			sync2_ff <= sync1_ff;
		end
	end

	assign sense = can_phy_fault_pkg::phy_sense_type'(sync2_ff[10:0]);
	assign v2_uv = sync2_ff[11];
	assign batt_high = sync2_ff[12];
	assign batt_low = sync2_ff[13];
	assign tx_dom = sync2_ff[14];

	logic ot1_ff;
	logic ot2_ff;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ot1_ff <= 1'b0;
			ot2_ff <= 1'b0;
		end else begin
			ot1_ff <= i_over_temp;
			ot2_ff <= ot1_ff;
		end
	end
	assign otemp = ot2_ff;

	// ************************************************************
	// Register bus
	// ************************************************************
	can_phy_fault_pkg::xcvr_mode_type mode_ff;
	can_phy_fault_pkg::xcvr_mode_type eff_mode;
	logic [2:0] mask_ff;
	logic [1:0] supply_ff;
	logic [7:0] err_ff;
	logic [7:0] active;
	logic ack_ff;
	logic req;
	logic rd_err;
	logic [31:0] nxt_dat;

	assign req = i_wb_cyc & i_wb_stb & ~ack_ff;
	assign rd_err = req & ~i_wb_we & (i_wb_adr == `ADDR_ERR_HIGH ||
		i_wb_adr == `ADDR_ERR_LOW);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req;
		end
	end
	assign o_wb_ack = ack_ff;

	// Mode is applied as soon as it is written, except the reserved value 3, which is ignored.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			mode_ff <= can_phy_fault_pkg::xcvr_mode_type'(`MODE_RESET);
			mask_ff <= `MASK_RESET;
		end else if (req && i_wb_we && i_wb_sel[0]) begin
			if (i_wb_adr == `ADDR_MODE && i_wb_dat[1:0] != 2'h3) begin
				mode_ff <= can_phy_fault_pkg::xcvr_mode_type'(i_wb_dat[1:0]);
			end
			if (i_wb_adr == `ADDR_IRQ_MASK) begin
				mask_ff <= i_wb_dat[2:0];
			end
		end
	end

	always_comb begin
		nxt_dat = 32'h0000_0000;
		unique case (i_wb_adr)
			`ADDR_MODE: nxt_dat[1:0] = mode_ff;
			`ADDR_SUPPLY: nxt_dat[1:0] = supply_ff;
			`ADDR_ERR_HIGH: nxt_dat[3:0] = err_ff[7:4];
			`ADDR_ERR_LOW: nxt_dat[3:0] = err_ff[3:0];
			`ADDR_IRQ_MASK: nxt_dat[2:0] = mask_ff;
			`ADDR_PHY_STATE: nxt_dat[9:0] = {eff_mode, o_phy};
			default: nxt_dat = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_wb_dat <= 32'h0000_0000;
		end else if (req && !i_wb_we) begin
			o_wb_dat <= nxt_dat;
		end
	end

	// ************************************************************
	// Supply flags
	// ************************************************************
	// Read clears a supply flag unless its condition is still present.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			supply_ff <= 2'h0;
		end else begin
			supply_ff[`SUP_BATT_FAIL] <= batt_low |
				(supply_ff[`SUP_BATT_FAIL] &
				~(req && !i_wb_we && i_wb_adr == `ADDR_SUPPLY));
			supply_ff[`SUP_BATT_HIGH] <= batt_high |
				(supply_ff[`SUP_BATT_HIGH] &
				~(req && !i_wb_we && i_wb_adr == `ADDR_SUPPLY));
		end
	end

	// ************************************************************
	// Failure filters
	// ************************************************************
	logic det_on;
	assign det_on = (eff_mode != can_phy_fault_pkg::MODE_STANDBY);

	// Standby keeps only the low-power detectors for 3, 4, 7 and 8.
	always_comb begin
		active = sense.fail_det & (det_on ? 8'hFF : 8'hCC);
	end

	logic [23:0] f3_cnt_ff;
	logic [23:0] f6_cnt_ff;
	logic [23:0] f47_cnt_ff;
	logic f3_sw_ff;
	logic f6_sw_ff;
	logic f47_sw_ff;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			f3_cnt_ff <= 24'h00_0000;
			f3_sw_ff <= 1'b0;
		end else if (f3_sw_ff == active[2]) begin
			f3_cnt_ff <= 24'h00_0000;
		end else if (f3_cnt_ff >= 24'(active[2] ? FAIL3_DETECT - 1 :
			FAIL36_RECOVER - 1)) begin
			f3_sw_ff <= active[2];
			f3_cnt_ff <= 24'h00_0000;
		end else begin
			f3_cnt_ff <= f3_cnt_ff + 24'h00_0001;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			f6_cnt_ff <= 24'h00_0000;
			f6_sw_ff <= 1'b0;
		end else if (f6_sw_ff == active[5]) begin
			f6_cnt_ff <= 24'h00_0000;
		end else if (f6_cnt_ff >= 24'(active[5] ? FAIL6_DETECT - 1 :
			FAIL36_RECOVER - 1)) begin
			f6_sw_ff <= active[5];
			f6_cnt_ff <= 24'h00_0000;
		end else begin
			f6_cnt_ff <= f6_cnt_ff + 24'h00_0001;
		end
	end

	// Failures 4 and 7 enter after a timeout, leave after the
	// differential level stays recessive for the recovery time.
	logic f47_cond;
	assign f47_cond = f47_sw_ff ? (active[3] | active[6] | sense.diff_dom) :
		(active[3] | active[6]);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			f47_cnt_ff <= 24'h00_0000;
			f47_sw_ff <= 1'b0;
		end else if (f47_sw_ff == f47_cond) begin
			f47_cnt_ff <= 24'h00_0000;
		end else if (f47_cnt_ff >= 24'(f47_cond ? FAIL47_TIMEOUT - 1 :
			FAIL478_RECOVER - 1)) begin
			f47_sw_ff <= f47_cond;
			f47_cnt_ff <= 24'h00_0000;
		end else begin
			f47_cnt_ff <= f47_cnt_ff + 24'h00_0001;
		end
	end

	// ************************************************************
	// Wiring error flags
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_err
			logic rd_bit;
			assign rd_bit = rd_err &&
				((g >= 4) == (i_wb_adr == `ADDR_ERR_HIGH));
			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					err_ff[g] <= 1'b0;
				end else if (active[g]) begin
					err_ff[g] <= 1'b1;
				end else if (rd_bit) begin
					err_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ************************************************************
	// Dominant transmit guard
	// ************************************************************
	logic [23:0] txd_cnt_ff;
	logic tx_lock_ff;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			txd_cnt_ff <= 24'h00_0000;
			tx_lock_ff <= 1'b0;
		end else if (!tx_dom) begin
			txd_cnt_ff <= 24'h00_0000;
			tx_lock_ff <= 1'b0;
		end else if (txd_cnt_ff >= 24'(TX_DOM_LIMIT)) begin
			tx_lock_ff <= 1'b1;
		end else begin
			txd_cnt_ff <= txd_cnt_ff + 24'h00_0001;
		end
	end

	// ************************************************************
	// Mode and front-end control
	// ************************************************************
	assign eff_mode = v2_uv ? can_phy_fault_pkg::MODE_STANDBY : mode_ff;

	logic tx_ok;
	logic rx_bus;
	assign tx_ok = (eff_mode == can_phy_fault_pkg::MODE_FULL) & ~tx_lock_ff &
		~otemp;

	always_comb begin
		if (f47_sw_ff || f3_sw_ff || f6_sw_ff) begin
			rx_bus = f3_sw_ff ? sense.canl_dom : sense.canh_dom;
		end else begin
			rx_bus = sense.diff_dom;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_phy <= '0;
			o_rx_dom <= 1'b0;
		end else begin
			o_phy.canh_drv_en <= tx_ok & ~f3_sw_ff & ~active[7];
			o_phy.canl_drv_en <= tx_ok & ~f6_sw_ff & ~f47_sw_ff;
			o_phy.high_term_ground_switch <= ~f3_sw_ff & ~active[7];
			o_phy.low_term_v2_switch <= det_on & ~f6_sw_ff & ~f47_sw_ff;
			o_phy.low_term_battery_switch <= ~det_on |
				(~f6_sw_ff & ~f47_sw_ff & 1'b0);
			o_phy.canl_weak_pullup <= f47_sw_ff;
			o_phy.rx_enable <= det_on;
			o_phy.single_wire <= f3_sw_ff | f6_sw_ff | f47_sw_ff;
			// A locked transmitter leaves the node receive-only, so RX
			// reports TX as well as the bus.
			o_rx_dom <= det_on & (rx_bus |
				((eff_mode == can_phy_fault_pkg::MODE_RX_ONLY | tx_lock_ff) &
				tx_dom));
		end
	end

	// ************************************************************
	// Interrupt
	// ************************************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_int_n <= 1'b1;
		end else begin
			o_int_n <= ~((supply_ff[`SUP_BATT_FAIL] & mask_ff[`MASK_BATT_FAIL]) |
				(supply_ff[`SUP_BATT_HIGH] & mask_ff[`MASK_BATT_HIGH]) |
				((|err_ff) & mask_ff[`MASK_WIRING]));
		end
	end

endmodule : can_phy_fault_manager

/* rtl/can_phy_fault_defines.svh */
`ifndef CAN_PHY_FAULT_DEFINES_SVH
`define CAN_PHY_FAULT_DEFINES_SVH

// Register word byte addresses.
`define ADDR_MODE 8'h00
`define ADDR_SUPPLY 8'h04
`define ADDR_ERR_HIGH 8'h08
`define ADDR_ERR_LOW 8'h0C
`define ADDR_IRQ_MASK 8'h10
`define ADDR_PHY_STATE 8'h14

// Supply status fields.
`define SUP_BATT_FAIL 0
`define SUP_BATT_HIGH 1

// Interrupt mask fields: 0 battery fail, 1 battery high, 2 wiring.
`define MASK_BATT_FAIL 0
`define MASK_BATT_HIGH 1
`define MASK_WIRING 2
`define MASK_RESET 3'h7

// Mode reset value: bus standby.
`define MODE_RESET 2'h0

// Dominant transmit timeout, 2.0 ms at 20 MHz.
`define CLK_HZ 20000000
`define TX_DOM_US 2000
`define TX_DOM_CYC ((`CLK_HZ / 1000000) * `TX_DOM_US)

// Filter defaults in cycles.
`define FAIL3_DETECT_CYC 40
`define FAIL6_DETECT_CYC 40
`define FAIL36_RECOVER_CYC 40
`define FAIL47_TIMEOUT_CYC 40
`define FAIL478_RECOVER_CYC 40

`endif

/* rtl/can_phy_fault_pkg.sv */
package can_phy_fault_pkg;

	typedef enum logic [1:0] {
		MODE_STANDBY = 2'b00,
		MODE_FULL = 2'b01,
		MODE_RX_ONLY = 2'b10,
		MODE_RSVD = 2'b11
	} xcvr_mode_type;

	// Driver and switch controls toward the analog front end.
	typedef struct packed {
		logic canh_drv_en;
		logic canl_drv_en;
		logic high_term_ground_switch;
		logic low_term_v2_switch;
		logic low_term_battery_switch;
		logic canl_weak_pullup;
		logic rx_enable;
		logic single_wire;
	} phy_ctrl_type;

	// Synchronised comparator and detector inputs.
	typedef struct packed {
		logic diff_dom;
		logic canh_dom;
		logic canl_dom;
		logic [7:0] fail_det;
	} phy_sense_type;

endpackage : can_phy_fault_pkg

/* sim/can_phy_fault_checker.sv */
`timescale 1ns/1ns
// ************************************************
// Port checker for the fault manager.
// ************************************************
module can_phy_fault_checker #(
	parameter int FAIL47_TIMEOUT = 40,
	parameter int TX_DOM_LIMIT = 40000
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic o_wb_ack,
	input wire logic i_tx_dom,
	input wire logic o_rx_dom,
	input wire logic [10:0] i_sense,
	input wire logic i_v2_undervolt,
	input wire logic i_over_temp,
	input wire can_phy_fault_pkg::phy_ctrl_type o_phy
);
	int tx_ff;
	int f47_ff;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Counters saturate so that long stalls cannot wrap them.
	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_tx_dom) tx_ff <= 0;
		else if (tx_ff < TX_DOM_LIMIT + 8) tx_ff <= tx_ff + 1;
	end
	always_ff @(posedge i_mclk) begin
		if (i_rst || !(i_sense[3] | i_sense[6]) || !o_phy.rx_enable) f47_ff <= 0;
		else if (f47_ff < FAIL47_TIMEOUT + 8) f47_ff <= f47_ff + 1;
	end
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");
	a_ack_prompt: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not answered next cycle");
	a_uv_standby: assert property (i_v2_undervolt [*4] |-> !o_phy.canh_drv_en && !o_phy.canl_drv_en && !o_phy.rx_enable)
		else $error("undervolt did not force standby");
	a_hot_notx: assert property (i_over_temp [*4] |-> !o_phy.canh_drv_en && !o_phy.canl_drv_en)
		else $error("drivers on while over temperature");
	a_f8_canh: assert property (i_sense[7] [*4] |-> !o_phy.canh_drv_en && !o_phy.high_term_ground_switch)
		else $error("failure 8 left high side active");
	a_f47_cut: assert property (f47_ff > FAIL47_TIMEOUT + 4 |-> !o_phy.canl_drv_en && !o_phy.low_term_v2_switch && !o_phy.low_term_battery_switch && o_phy.canl_weak_pullup)
		else $error("failure 4 or 7 not handled after timeout");
	a_rx_follow: assert property (($stable(i_sense) && !i_tx_dom && i_sense[7:0] == 8'h00 && o_phy.rx_enable && !o_phy.single_wire) [*6] |-> o_rx_dom == i_sense[10])
		else $error("receive output not following bus");
	a_tx_stuck: assert property (tx_ff > TX_DOM_LIMIT + 4 |-> !o_phy.canh_drv_en && !o_phy.canl_drv_en)
		else $error("stuck dominant transmit kept drivers");
	c_tx_stuck: cover property (tx_ff > TX_DOM_LIMIT + 4);
	c_f47: cover property (f47_ff > FAIL47_TIMEOUT + 4);
	c_uv: cover property (i_v2_undervolt [*4]);
endmodule : can_phy_fault_checker

bind can_phy_fault_manager can_phy_fault_checker #(
	.FAIL47_TIMEOUT(FAIL47_TIMEOUT), .TX_DOM_LIMIT(TX_DOM_LIMIT)
) chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_tx_dom(i_tx_dom),
	.o_rx_dom(o_rx_dom), .i_sense(i_sense), .i_v2_undervolt(i_v2_undervolt),
	.i_over_temp(i_over_temp), .o_phy(o_phy));

/* sim/can_bus_model.sv */
`timescale 1ns/1ns
// ************************************************
// Two-wire bus: dominant wins over recessive.
// ************************************************
module can_bus_model (
	input wire logic i_tx_dom,
	input wire logic i_ext_dom,
	input wire logic [7:0] i_fail,
	input wire can_phy_fault_pkg::phy_ctrl_type i_phy,
	output logic [10:0] o_sense
);
	logic bus_dom;
	// The node pulls the bus only through an enabled driver.
	assign bus_dom = i_ext_dom | (i_tx_dom & (i_phy.canh_drv_en | i_phy.canl_drv_en));
	assign o_sense = {bus_dom, bus_dom, bus_dom, i_fail};
endmodule : can_bus_model

/* sim/tb.sv */
`timescale 1ns/1ns
// ************************************************
// Fault manager testbench.
// ************************************************
module tb;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} row_type;
	localparam row_type ROWS [7] = '{'{8'h00, 1, 1}, '{8'h00, 3, 1},
		'{8'h10, 0, 0}, '{8'h10, 7, 7}, '{8'h20, 5, 0}, '{8'h00, 2, 2},
		'{8'h00, 1, 1}};
	logic i_mclk, i_rst, cyc, we, tx, ext, blo, bhi, uv, hot, ack, rxd, intn;
	logic [7:0] adr, fail, a;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd, b;
	logic [10:0] sense;
	can_phy_fault_pkg::phy_ctrl_type phy, p;
	int n_mismatch, num_checks;
	can_phy_fault_manager #(.FAIL3_DETECT(8), .FAIL6_DETECT(8),
		.FAIL36_RECOVER(8), .FAIL47_TIMEOUT(8), .FAIL478_RECOVER(8),
		.TX_DOM_LIMIT(50)) dut (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_tx_dom(tx), .o_rx_dom(rxd), .i_sense(sense), .i_batt_low(blo),
		.i_batt_high(bhi), .i_v2_undervolt(uv), .i_over_temp(hot),
		.o_phy(phy), .o_int_n(intn));
	can_bus_model bus (.i_tx_dom(tx), .i_ext_dom(ext), .i_fail(fail),
		.i_phy(phy), .o_sense(sense));
	initial begin
		i_mclk = 0;
		forever #25 i_mclk = ~i_mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// The master never assumes a latency; ack or the 20-cycle bound ends a wait.
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int k;
		@(posedge i_mclk);
		cyc <= 1;
		we <= w;
		adr <= ad;
		wdat <= d;
		k = 0;
		do begin
			@(posedge i_mclk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) n_mismatch++;
		rd = rdat;
		cyc <= 0;
	endtask : wb
	task automatic idle(input int n);
		repeat (n) @(posedge i_mclk);
	endtask : idle
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	initial begin
		#1000000;
		n_mismatch++;
		results();
	end
	initial begin
		{i_rst, cyc, we, tx, ext, blo, bhi, uv, hot} = 9'h100;
		adr = 0;
		wdat = 0;
		fail = 0;
		sel = 4'h1;
		idle(3);
		i_rst <= 0;
		wb(0, 8'h00, 0);
		chk(rd, 0);
		wb(0, 8'h10, 0);
		chk(rd, 7);
		foreach (ROWS[i]) begin
			wb(1, ROWS[i].a, ROWS[i].d);
			wb(0, ROWS[i].a, 0);
			chk(rd, ROWS[i].e);
		end
		sel <= 4'h0;
		wb(1, 8'h00, 2);
		sel <= 4'h1;
		wb(0, 8'h00, 0);
		chk(rd, 1);
		wb(0, 8'h14, 0);
		chk(32'(rd[9:8]), 1);
		ext <= 1;
		idle(6);
		chk(32'(rxd), 1);
		ext <= 0;
		idle(6);
		chk(32'(rxd), 0);
		for (int n = 0; n < 8; n++) begin
			p = phy;
			fail <= 8'h01 << n;
			idle(30);
			if (n == 0 || n == 1 || n == 4) chk(32'(phy), 32'(p));
			if (n == 2 || n == 7) chk({phy.canh_drv_en, phy.high_term_ground_switch}, 0);
			if (n == 3 || n == 5 || n == 6) chk({phy.canl_drv_en, phy.low_term_v2_switch, phy.low_term_battery_switch}, 0);
			if (n == 2 || n == 5) chk(32'(phy.single_wire), 1);
			if (n == 3 || n == 6) chk({phy.canl_weak_pullup, phy.single_wire}, 3);
			a = n < 4 ? 8'h0C : 8'h08;
			b = 32'h1 << (n % 4);
			wb(0, a, 0);
			chk(rd, b);
			chk(32'(intn), 0);
			wb(0, a, 0);
			chk(rd, b);
			fail <= 0;
			idle(30);
			chk(32'(phy), 32'(p));
			wb(0, a, 0);
			chk(rd, b);
			wb(0, a, 0);
			chk(rd, 0);
			idle(2);
			chk(32'(intn), 1);
		end
		for (int k = 0; k < 2; k++) begin
			p = phy;
			{bhi, blo} <= 2'b01 << k;
			idle(6);
			chk(32'(phy), 32'(p));
			wb(0, 8'h04, 0);
			chk(rd, 1 << k);
			{bhi, blo} <= 2'b00;
			idle(6);
			wb(0, 8'h04, 0);
			chk(rd, 1 << k);
			wb(0, 8'h04, 0);
			chk(rd, 0);
		end
		hot <= 1;
		idle(6);
		chk({phy.canh_drv_en, phy.canl_drv_en, phy.rx_enable}, 1);
		hot <= 0;
		idle(6);
		chk(32'(phy), 32'(p));
		tx <= 1;
		idle(60);
		chk({phy.canh_drv_en, phy.canl_drv_en}, 0);
		chk(32'(rxd), 1);
		tx <= 0;
		wb(1, 8'h00, 2);
		idle(6);
		chk({phy.canh_drv_en, phy.canl_drv_en}, 0);
		tx <= 1;
		idle(6);
		chk(32'(rxd), 1);
		tx <= 0;
		fail <= 8'h01;
		idle(30);
		wb(0, 8'h0C, 0);
		chk(rd, 1);
		fail <= 0;
		wb(1, 8'h00, 0);
		idle(6);
		chk({phy.canh_drv_en, phy.canl_drv_en, phy.rx_enable}, 0);
		chk(32'(phy.low_term_battery_switch), 1);
		wb(1, 8'h00, 1);
		uv <= 1;
		idle(6);
		wb(0, 8'h14, 0);
		chk(32'(rd[9:8]), 0);
		uv <= 0;
		results();
	end
endmodule : tb
